// >>> core/dsc_regs.sv
// Overview of operation
// RULE_01 - status bits 0,2,4-7: lock, fsc lock, under, over, peak, kill.
// RULE_02 - status bit 1 sets on lock loss and holds until the status read.
// RULE_03 - status bit 3 reads one while a 50 Hz field rate is detected.
// RULE_04 - a read-only identifier byte gives the revision, ignoring writes.
// RULE_05 - analog control bit 1 forces the timing drivers on over pin and input.
// RULE_06 - software writes reserved analog control bits with their defaults.
// RULE_07 - fine clamp length picks 16, 32, 64 or 128 cycles of slow current.
// RULE_08 - fast clamp length picks 16, 32, 64 or 128 cycles of fast current.
// RULE_09 - analog clamp bit 4 enables the clamp current sources.
// RULE_10 - analog clamp bit 5 enables the voltage clamp.
// RULE_11 - digital clamp bits 3:0 are the offset's top nibble, added to samples.
// RULE_12 - the manual offset acts only in manual mode.
// RULE_13 - digital clamp bit 7 selects manual mode, which acts on chroma only.
// RULE_14 - digital clamp bit 4 freezes the clamp loop while set.
// RULE_15 - digital clamp bits 6:5 pick 1 s, 0.5 s, 0.1 s or quality-driven.
// RULE_16 - software writes zero to analog clamp bits 7 and 6.
// RULE_17 - flags are sampled at each read; only lost lock is sticky.
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "dsc_consts.svh"

module dsc_regs #(
    parameter int          SAMPLE_W    = 12,
    parameter logic [7:0]  REVISION_ID = 8'h5A, // arbitrary value
    parameter logic [11:0] BLACK_LEVEL = 12'h100,
    parameter int TC_SLOW_CYC = `DSC_TC_SLOW_MS * `DSC_CLK_KHZ,
    parameter int TC_MED_CYC  = `DSC_TC_MED_MS * `DSC_CLK_KHZ,
    parameter int TC_FAST_CYC = `DSC_TC_FAST_MS * `DSC_CLK_KHZ
) (
    // clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic [31:0]                hrdata,
    output logic                       hresp,
    // decoder conditions, asynchronous to hclk
    input  wire dsc_pkg::dsc_cond_type cond_async,
    // timing output control pins
    input  wire logic                  output_enable_n,
    input  wire logic                  timing_output_disable,
    output logic                       timing_drive_en,
    // analog clamp front end
    input  wire logic                  clamp_start,
    output logic                       current_sources_en,
    output logic                       voltage_clamp_en,
    output logic                       fine_current_on,
    output logic                       fast_current_on,
    // digital clamp datapath
    input  wire logic [7:0]            clamp_offset_low,
    input  wire logic                  video_quality_setting,
    input  wire logic [SAMPLE_W-1:0]   luma_sample,
    input  wire logic [SAMPLE_W-1:0]   chroma_sample,
    output logic [SAMPLE_W-1:0]        luma_core,
    output logic [SAMPLE_W-1:0]        chroma_core,
    // interrupt
    output logic                       irq
);
    import dsc_pkg::*;

    localparam int STEP_SLOW = (TC_SLOW_CYC / `DSC_LOOP_STEPS) > 0 ?
                               (TC_SLOW_CYC / `DSC_LOOP_STEPS) : 1;
    localparam int STEP_MED  = (TC_MED_CYC / `DSC_LOOP_STEPS) > 0 ?
                               (TC_MED_CYC / `DSC_LOOP_STEPS) : 1;
    localparam int STEP_FAST = (TC_FAST_CYC / `DSC_LOOP_STEPS) > 0 ?
                               (TC_FAST_CYC / `DSC_LOOP_STEPS) : 1;

    dsc_bus_state_type bus_state_ff;
    dsc_bus_state_type nxt_bus_state;
    logic [7:0]        addr_idx_ff;
    logic [31:0]       rd_data_ff;
    logic              addr_ok;
    logic [7:0]        addr_idx;
    logic              wr_en;
    logic [7:0]        wr_byte;
    logic              rd_load;

    dsc_cond_type      cond_meta_ff;
    dsc_cond_type      cond_ff;
    logic              lock_prev_ff;
    logic              under_prev_ff;
    logic              over_prev_ff;
    logic              lost_lock_ff;
    logic              lock_fall;

    logic [7:0]        ana_ctrl_ff;
    dsc_ana_clamp_type ana_clamp_ff;
    dsc_dig_clamp_type dig_clamp_ff;
    logic [3:0]        irq_status_ff;
    logic [3:0]        irq_mask_ff;
    logic [3:0]        irq_event;
    logic [7:0]        status_byte;

    logic [1:0]        oe_meta_ff;
    logic [8:0]        fine_cnt_ff;
    logic [8:0]        fast_cnt_ff;
    logic [8:0]        fine_len;
    logic [8:0]        fast_len;

    logic [31:0]       step_cnt_ff;
    logic [31:0]       step_len;
    logic [11:0]       loop_offset_ff;
    logic [11:0]       chroma_offset;
    logic              step_due;

    // address phase decode; every index answers, unmapped ones with zero, and haddr[1:0] is ignored
    assign addr_idx = haddr[9:2];
    assign addr_ok  = hsel && hready && htrans[1];
    assign hresp    = 1'b0;
    assign hreadyout = (bus_state_ff != DSC_RDWAIT);
    assign hrdata   = rd_data_ff;

    // bus phase: writes take no wait, reads take one so a read
    // right behind a write sees the written value
    always_comb begin
        nxt_bus_state = bus_state_ff;
        case (bus_state_ff)
            DSC_IDLE, DSC_WRITE, DSC_RDDONE: begin
                if (addr_ok && hwrite) begin
                    nxt_bus_state = DSC_WRITE;
                end else if (addr_ok) begin
                    nxt_bus_state = DSC_RDWAIT;
                end else begin
                    nxt_bus_state = DSC_IDLE;
                end
            end
            DSC_RDWAIT: nxt_bus_state = DSC_RDDONE;
            default:    nxt_bus_state = DSC_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state_ff <= DSC_IDLE;
            addr_idx_ff  <= 8'h00;
        end else begin
            bus_state_ff <= nxt_bus_state;
            if (addr_ok) begin
                addr_idx_ff <= addr_idx;
            end
        end
    end

    assign wr_en   = (bus_state_ff == DSC_WRITE);
    assign wr_byte = hwdata[7:0];
    assign rd_load = (bus_state_ff == DSC_RDWAIT);

    // two-flop synchroniser on every condition and the enable pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cond_meta_ff <= '0;
            cond_ff      <= '0;
            oe_meta_ff   <= 2'b11;
        end else begin
            cond_meta_ff <= cond_async;
            cond_ff      <= cond_meta_ff;
            oe_meta_ff   <= {oe_meta_ff[0], output_enable_n};
        end
    end

    // edge history, read only from the second synchroniser stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_prev_ff  <= 1'b0;
            under_prev_ff <= 1'b0;
            over_prev_ff  <= 1'b0;
        end else begin
            lock_prev_ff  <= cond_ff.in_lock;
            under_prev_ff <= cond_ff.adc_under;
            over_prev_ff  <= cond_ff.adc_over;
        end
    end

    assign lock_fall = lock_prev_ff && !cond_ff.in_lock;

    // lost lock sticks until the status byte is read; a loss in the
    // read cycle itself survives to the next read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lost_lock_ff <= 1'b0;
        end else if (lock_fall) begin
            lost_lock_ff <= 1'b1; // RULE_02
        end else if (rd_load && addr_idx_ff == `DSC_IDX_STATUS) begin
            lost_lock_ff <= 1'b0; // RULE_02
        end
    end

    // present-state flags come straight from the synchroniser
    always_comb begin
        status_byte = 8'h00;
        status_byte[`DSC_ST_LOCK]       = cond_ff.in_lock; // RULE_01
        status_byte[`DSC_ST_LOST_LOCK]  = lost_lock_ff; // RULE_02
        status_byte[`DSC_ST_FSC_LOCK]   = cond_ff.fsc_lock; // RULE_01
        status_byte[`DSC_ST_FIELD_50HZ] = cond_ff.field_50hz; // RULE_03
        status_byte[`DSC_ST_ADC_UNDER]  = cond_ff.adc_under; // RULE_17
        status_byte[`DSC_ST_ADC_OVER]   = cond_ff.adc_over; // RULE_17
        status_byte[`DSC_ST_WHITE_PEAK] = cond_ff.white_peak; // RULE_01
        status_byte[`DSC_ST_COLOR_KILL] = cond_ff.color_kill; // RULE_01
    end

    // read data is captured in the wait cycle, unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_data_ff <= 32'h0000_0000;
        end else if (rd_load) begin
            case (addr_idx_ff)
                `DSC_IDX_STATUS:     rd_data_ff <= {24'h0, status_byte};
                `DSC_IDX_REVISION:   rd_data_ff <= {24'h0, REVISION_ID}; // RULE_04
                `DSC_IDX_ANA_CTRL:   rd_data_ff <= {24'h0, ana_ctrl_ff};
                `DSC_IDX_ANA_CLAMP:  rd_data_ff <= {24'h0, ana_clamp_ff};
                `DSC_IDX_DIG_CLAMP:  rd_data_ff <= {24'h0, dig_clamp_ff};
                `DSC_IDX_IRQ_STATUS: rd_data_ff <= {28'h0, irq_status_ff};
                `DSC_IDX_IRQ_MASK:   rd_data_ff <= {28'h0, irq_mask_ff};
                default:             rd_data_ff <= 32'h0000_0000;
            endcase
        end
    end

    // control bytes; the revision byte has no write path at all
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ana_ctrl_ff  <= `DSC_RST_ANA_CTRL;
            ana_clamp_ff <= `DSC_RST_ANA_CLAMP;
            dig_clamp_ff <= `DSC_RST_DIG_CLAMP;
        end else if (wr_en) begin
            case (addr_idx_ff)
                // reserved bits are stored as written; software keeps them
                `DSC_IDX_ANA_CTRL:  ana_ctrl_ff  <= wr_byte; // RULE_06
                `DSC_IDX_ANA_CLAMP: ana_clamp_ff <= wr_byte; // RULE_16
                `DSC_IDX_DIG_CLAMP: dig_clamp_ff <= wr_byte;
                default: ;
            endcase
        end
    end

    // interrupt events: lock lost or gained, converter range errors
    always_comb begin
        irq_event = 4'h0;
        irq_event[`DSC_IRQ_LOST_LOCK] = lock_fall;
        irq_event[`DSC_IRQ_ADC_UNDER] = cond_ff.adc_under && !under_prev_ff;
        irq_event[`DSC_IRQ_ADC_OVER]  = cond_ff.adc_over && !over_prev_ff;
        irq_event[`DSC_IRQ_LOCK_GAIN] = cond_ff.in_lock && !lock_prev_ff;
    end

    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status_ff <= 4'h0;
        end else if (wr_en && addr_idx_ff == `DSC_IDX_IRQ_STATUS) begin
            irq_status_ff <= (irq_status_ff & ~hwdata[3:0]) | irq_event;
        end else begin
            irq_status_ff <= irq_status_ff | irq_event;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_ff <= `DSC_RST_IRQ_MASK;
        end else if (wr_en && addr_idx_ff == `DSC_IDX_IRQ_MASK) begin
            irq_mask_ff <= hwdata[3:0];
        end
    end

    // registered so the level carries no decode glitches
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_ff & irq_mask_ff);
        end
    end

    // timing drivers: force bit overrides pin and disable input
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timing_drive_en <= 1'b0;
        end else begin
            timing_drive_en <= ana_ctrl_ff[`DSC_TIM_FORCE_BIT] ||
                               (!oe_meta_ff[1] &&
                                !timing_output_disable); // RULE_05
        end
    end

    // clamp current lengths are 16 shifted left by the code
    assign fine_len = `DSC_CLAMP_BASE_LEN <<
                      ana_clamp_ff.fine_clamp_length; // RULE_07
    assign fast_len = `DSC_CLAMP_BASE_LEN <<
                      ana_clamp_ff.fast_clamp_length; // RULE_08

    // a clamp start with current_clamp_on set loads both length counters; a start while a
    // pulse runs restarts it rather than stacking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fine_cnt_ff <= 9'd0;
            fast_cnt_ff <= 9'd0;
        end else if (!ana_clamp_ff.current_clamp_on) begin
            fine_cnt_ff <= 9'd0; // RULE_09
            fast_cnt_ff <= 9'd0; // RULE_09
        end else if (clamp_start) begin
            fine_cnt_ff <= fine_len; // RULE_07
            fast_cnt_ff <= fast_len; // RULE_08
        end else begin
            if (fine_cnt_ff != 9'd0) begin
                fine_cnt_ff <= fine_cnt_ff - 9'd1;
            end
            if (fast_cnt_ff != 9'd0) begin
                fast_cnt_ff <= fast_cnt_ff - 9'd1;
            end
        end
    end

    // current on exactly while its counter is non-zero
    assign fine_current_on    = (fine_cnt_ff != 9'd0); // RULE_07
    assign fast_current_on    = (fast_cnt_ff != 9'd0); // RULE_08
    assign current_sources_en = ana_clamp_ff.current_clamp_on; // RULE_09
    assign voltage_clamp_en   = ana_clamp_ff.voltage_clamp_on; // RULE_10

    // loop step period from the time constant; the quality setting
    // picks fast tracking for poor video and slow for good
    always_comb begin
        case (dig_clamp_ff.clamp_time_constant)
            2'b00:   step_len = STEP_SLOW; // RULE_15
            2'b01:   step_len = STEP_MED; // RULE_15
            2'b10:   step_len = STEP_FAST; // RULE_15
            default: step_len = video_quality_setting ?
                                STEP_SLOW : STEP_FAST; // RULE_15
        endcase
    end

    assign step_due = (step_cnt_ff >= step_len - 32'd1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_cnt_ff <= 32'd0;
        end else if (step_due || dig_clamp_ff.clamp_loop_freeze) begin
            step_cnt_ff <= 32'd0; // RULE_14
        end else begin
            step_cnt_ff <= step_cnt_ff + 32'd1;
        end
    end

    // the loop moves one lsb per step toward the black level,
    // sampled on the luma path during the clamp window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loop_offset_ff <= 12'h000;
        end else if (!dig_clamp_ff.clamp_loop_freeze && step_due &&
                     fine_current_on) begin // RULE_14
            if (12'(luma_sample + loop_offset_ff) < BLACK_LEVEL) begin
                loop_offset_ff <= loop_offset_ff + 12'h001;
            end else if (12'(luma_sample + loop_offset_ff) >
                         BLACK_LEVEL) begin
                loop_offset_ff <= loop_offset_ff - 12'h001;
            end
        end
    end

    // manual offset replaces the loop on chroma only, in manual mode
    assign chroma_offset = dig_clamp_ff.clamp_mode_select ?
                           {dig_clamp_ff.manual_clamp_offset,
                            clamp_offset_low} : // RULE_11
                           loop_offset_ff; // RULE_12

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            luma_core   <= '0;
            chroma_core <= '0;
        end else begin
            luma_core   <= SAMPLE_W'(luma_sample + loop_offset_ff);
            chroma_core <= SAMPLE_W'(chroma_sample +
                                     chroma_offset); // RULE_13
        end
    end

endmodule // dsc_regs

// >>> core/dsc_consts.svh
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH

// register indices; byte address is four times the index
`define DSC_IDX_STATUS      8'h10
`define DSC_IDX_REVISION    8'h11
`define DSC_IDX_ANA_CTRL    8'h13
`define DSC_IDX_ANA_CLAMP   8'h14
`define DSC_IDX_DIG_CLAMP   8'h15
`define DSC_IDX_IRQ_STATUS  8'h20
`define DSC_IDX_IRQ_MASK    8'h21

// reset values
`define DSC_RST_ANA_CTRL    8'h45
`define DSC_RST_ANA_CLAMP   8'h30
`define DSC_RST_DIG_CLAMP   8'h00
`define DSC_RST_IRQ_MASK    4'h0

// status byte bit positions
`define DSC_ST_LOCK         0
`define DSC_ST_LOST_LOCK    1
`define DSC_ST_FSC_LOCK     2
`define DSC_ST_FIELD_50HZ   3
`define DSC_ST_ADC_UNDER    4
`define DSC_ST_ADC_OVER     5
`define DSC_ST_WHITE_PEAK   6
`define DSC_ST_COLOR_KILL   7

// analog control byte fields
`define DSC_TIM_FORCE_BIT   1
`define DSC_ANA_CTRL_RSVD   8'hFD

// interrupt bit positions
`define DSC_IRQ_LOST_LOCK   0
`define DSC_IRQ_ADC_UNDER   1
`define DSC_IRQ_ADC_OVER    2
`define DSC_IRQ_LOCK_GAIN   3

// clamp current base length in cycles (code 00)
`define DSC_CLAMP_BASE_LEN  9'd16

// clock and loop time constants
`define DSC_CLK_KHZ         50000
`define DSC_TC_SLOW_MS      1000
`define DSC_TC_MED_MS       500
`define DSC_TC_FAST_MS      100
`define DSC_LOOP_STEPS      4096

`endif

// >>> core/dsc_pkg.sv
package dsc_pkg;

    // present-state inputs from the decoder core
    typedef struct packed {
        logic color_kill;
        logic white_peak;
        logic adc_over;
        logic adc_under;
        logic field_50hz;
        logic fsc_lock;
        logic in_lock;
    } dsc_cond_type;

    // analog clamp control byte
    typedef struct packed {
        logic [1:0] reserved;
        logic       voltage_clamp_on;
        logic       current_clamp_on;
        logic [1:0] fast_clamp_length;
        logic [1:0] fine_clamp_length;
    } dsc_ana_clamp_type;

    // digital clamp control byte
    typedef struct packed {
        logic       clamp_mode_select;
        logic [1:0] clamp_time_constant;
        logic       clamp_loop_freeze;
        logic [3:0] manual_clamp_offset;
    } dsc_dig_clamp_type;

    // bus phase tracker, gray along idle-write-rdwait-rddone
    typedef enum logic [1:0] {
        DSC_IDLE   = 2'b00,
        DSC_WRITE  = 2'b01,
        DSC_RDWAIT = 2'b11,
        DSC_RDDONE = 2'b10
    } dsc_bus_state_type;

endpackage

// >>> verification/dsc_regs_monitor.sv
`timescale 1ns/1ps
`include "dsc_consts.svh"

module dsc_regs_monitor #(
    parameter logic [7:0] REVISION_ID = 8'h5A // arbitrary value
) (
    // clock and reset
    input wire logic                  hclk,
    input wire logic                  hresetn,
    // register bus
    input wire logic                  hsel,
    input wire logic [31:0]           haddr,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic                  hready,
    input wire logic                  hreadyout,
    input wire logic [31:0]           hrdata,
    // decoder side
    input wire dsc_pkg::dsc_cond_type cond_async,
    input wire logic                  output_enable_n,
    input wire logic                  timing_output_disable,
    input wire logic                  timing_drive_en,
    input wire logic                  clamp_start,
    input wire logic                  current_sources_en,
    input wire logic                  voltage_clamp_en,
    input wire logic                  fine_current_on,
    input wire logic                  fast_current_on
);
    import dsc_pkg::*;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // transfers taken at this edge
    logic rd_go, rd_st, wr_tk;
    assign rd_go = hsel && hready && htrans[1] && !hwrite;
    assign rd_st = rd_go && haddr[9:2] == `DSC_IDX_STATUS;
    assign wr_tk = hsel && hready && htrans[1] && hwrite;

    sequence rd_req(logic [7:0] idx);
        rd_go && haddr[9:2] == idx;
    endsequence
    sequence rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence

    // on-time counters; an overlong pulse fails before they wrap
    logic [8:0] fine_cnt_ff, fast_cnt_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fine_cnt_ff <= 9'h000;
            fast_cnt_ff <= 9'h000;
        end else begin
            fine_cnt_ff <= clamp_start ? 9'h000 : fine_cnt_ff + 9'(fine_current_on);
            fast_cnt_ff <= clamp_start ? 9'h000 : fast_cnt_ff + 9'(fast_current_on);
        end
    end

    AST_REV_READ: assert property (rd_req(`DSC_IDX_REVISION) |-> ##1
        rd_answer ##0 hrdata == {24'h000000, REVISION_ID})
        else $error("revision read wrong");
    AST_STATUS_LIVE: assert property (($stable(cond_async))[*4] ##0
        rd_st ##1 $stable(cond_async) ##1 $stable(cond_async) |->
        (hrdata[7:0] & 8'hFD) == {cond_async[6:1], 1'b0, cond_async[0]})
        else $error("status flags wrong");
    AST_LOST_LOCK: assert property ($fell(cond_async.in_lock) ##1
        (!rd_st)[*2] ##1 rd_st |-> ##1 rd_answer ##0 hrdata[1])
        else $error("lost lock not reported");
    AST_TIM_PINS: assert property ((!output_enable_n &&
        !timing_output_disable)[*4] |-> timing_drive_en)
        else $error("timing drivers off");
    AST_CLAMP_START: assert property (clamp_start && current_sources_en
        |=> (fine_current_on && fast_current_on)[*8])
        else $error("clamp current not started");
    AST_FINE_LEN: assert property (fine_cnt_ff <= 9'h080)
        else $error("fine current too long");
    AST_FAST_LEN: assert property (fast_cnt_ff <= 9'h080)
        else $error("fast current too long");
    AST_SRC_OFF: assert property (!current_sources_en ##1
        !current_sources_en |-> !fine_current_on && !fast_current_on)
        else $error("current on with sources off");
    AST_EN_WRITE: assert property ($changed(current_sources_en) ||
        $changed(voltage_clamp_en) |-> $past(wr_tk, 2))
        else $error("clamp enable moved without write");
endmodule // dsc_regs_monitor

bind dsc_regs dsc_regs_monitor #(.REVISION_ID(REVISION_ID)) u_mon (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
    .hrdata, .cond_async, .output_enable_n, .timing_output_disable,
    .timing_drive_en, .clamp_start, .current_sources_en, .voltage_clamp_en,
    .fine_current_on, .fast_current_on);

// >>> verification/decoder_status_clamp_regs_test.sv
`timescale 1ns/1ps
`include "dsc_consts.svh"

module decoder_status_clamp_regs_test;
    import dsc_pkg::*;

    localparam logic [7:0] REV = 8'hC3; // arbitrary value
    logic         hclk, hresetn, hsel, hwrite, hready, irq;
    logic         output_enable_n, timing_output_disable, timing_drive_en;
    logic         clamp_start, current_sources_en, voltage_clamp_en;
    logic         fine_current_on, fast_current_on, video_quality_setting;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    logic [3:0]   tv;
    logic [6:0]   pat;
    logic [7:0]   clamp_offset_low;
    logic [11:0]  luma_sample, chroma_sample, luma_core, chroma_core, auto_v;
    logic [31:0]  haddr, hwdata, hrdata, rd_smp, nf, nq;
    dsc_cond_type cond_async;
    logic [3:0]   tim_tab [4] = '{4'h1, 4'h4, 4'h2, 4'hF};
    int           error_cnt = 0;
    int           checks = 0;

    // small loop time constants keep a loop step within reach
    dsc_regs #(.REVISION_ID(REV), .TC_SLOW_CYC(40960), .TC_MED_CYC(20480),
        .TC_FAST_CYC(4096)) uut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout(hready), .hrdata, .hresp(), .cond_async,
        .output_enable_n, .timing_output_disable, .timing_drive_en,
        .clamp_start, .current_sources_en, .voltage_clamp_en,
        .fine_current_on, .fast_current_on, .clamp_offset_low,
        .video_quality_setting, .luma_sample, .chroma_sample, .luma_core,
        .chroma_core, .irq);

    // 50 MHz clock
    initial hclk = 1'b0;
    always #10 hclk = ~hclk;

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // hready and hrdata read at the edge, before it updates them
    task wait_rdy();
        do @(posedge hclk); while (hready !== 1'b1);
        rd_smp = hrdata;
    endtask

    task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        htrans <= 2'b10;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        wait_rdy();
    endtask

    task rdc(input string nm, input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(nm, rd_smp, {24'h0, exp});
    endtask

    // one clamp window, counting cycles of each current
    task clamp_run();
        clamp_start <= 1'b1;
        @(posedge hclk);
        clamp_start <= 1'b0;
        nf = 32'h0;
        nq = 32'h0;
        repeat (200) begin
            @(posedge hclk);
            nf = nf + 32'(fine_current_on);
            nq = nq + 32'(fast_current_on);
        end
    endtask

    task final_report();
        if (error_cnt == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // watchdog well beyond the roughly 1100 cycles the tests need
    initial begin
        repeat (8000) @(posedge hclk);
        error_cnt++;
        final_report();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        cond_async = 7'h00;
        output_enable_n = 1'b1;
        timing_output_disable = 1'b1;
        clamp_start = 1'b0;
        clamp_offset_low = 8'h5C;
        video_quality_setting = 1'b1;
        luma_sample = 12'h200;
        chroma_sample = 12'h7F0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // defaults, unmapped space and the read-only identifier
        rdc("ana_ctrl", `DSC_IDX_ANA_CTRL, `DSC_RST_ANA_CTRL);
        rdc("ana_clamp", `DSC_IDX_ANA_CLAMP, `DSC_RST_ANA_CLAMP);
        rdc("dig_clamp", `DSC_IDX_DIG_CLAMP, `DSC_RST_DIG_CLAMP);
        bus(1'b1, 8'h12, 8'hFF);
        rdc("unmapped", 8'h12, 8'h00);
        bus(1'b1, `DSC_IDX_REVISION, 8'h00);
        rdc("revision", `DSC_IDX_REVISION, REV);
        // present-state flags, two patterns opposite in every bit but in_lock
        for (int i = 0; i < 2; i++) begin
            pat = (i == 0) ? 7'h2B : 7'h55;
            cond_async <= pat;
            repeat (4) @(posedge hclk);
            rdc("status", `DSC_IDX_STATUS, {pat[6:1], 1'b0, pat[0]});
        end
        // first read comes too early to see the loss; the next must
        cond_async.in_lock <= 1'b0;
        bus(1'b0, `DSC_IDX_STATUS, 8'h00);
        rdc("lost_set", `DSC_IDX_STATUS, {pat[6:1], 2'b10});
        rdc("lost_clear", `DSC_IDX_STATUS, {pat[6:1], 2'b00});
        // every event seen so far; the mask gates the line
        rdc("irq_status", `DSC_IDX_IRQ_STATUS, 8'h0F);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        bus(1'b1, `DSC_IDX_IRQ_MASK, 8'h01);
        repeat (2) @(posedge hclk);
        chk("irq_on", {31'h0, irq}, 32'h1);
        bus(1'b1, `DSC_IDX_IRQ_STATUS, 8'h01);
        repeat (2) @(posedge hclk);
        chk("irq_off", {31'h0, irq}, 32'h0);
        rdc("irq_w1c", `DSC_IDX_IRQ_STATUS, 8'h0E);
        // timing drivers: {force, pin, disable, expected}
        for (int i = 0; i < 4; i++) begin
            tv = tim_tab[i];
            bus(1'b1, `DSC_IDX_ANA_CTRL, `DSC_RST_ANA_CTRL | {6'h0, tv[3], 1'b0});
            output_enable_n <= tv[2];
            timing_output_disable <= tv[1];
            repeat (4) @(posedge hclk);
            chk("timing", {31'h0, timing_drive_en}, {31'h0, tv[0]});
        end
        // every length code, fine and fast crossed
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, `DSC_IDX_ANA_CLAMP, {4'h3, 2'(3 - c), 2'(c)});
            clamp_run();
            chk("fine_len", nf, 32'(16 << c));
            chk("fast_len", nq, 32'(16 << (3 - c)));
        end
        bus(1'b1, `DSC_IDX_ANA_CLAMP, 8'h0F);
        @(posedge hclk);
        chk("clamp_en", {30'h0, voltage_clamp_en, current_sources_en}, 32'h0);
        clamp_run();
        chk("src_off", nf | nq, 32'h0);
        // manual offset reaches chroma
        bus(1'b1, `DSC_IDX_DIG_CLAMP, 8'h8A);
        repeat (2) @(posedge hclk);
        chk("chroma_man", {20'h0, chroma_core},
            {20'h0, 12'(chroma_sample + {4'hA, clamp_offset_low})});
        // automatic mode with the loop frozen ignores the nibble
        bus(1'b1, `DSC_IDX_DIG_CLAMP, 8'h1A);
        repeat (2) @(posedge hclk);
        auto_v = chroma_core;
        bus(1'b1, `DSC_IDX_DIG_CLAMP, 8'h13);
        repeat (2) @(posedge hclk);
        chk("chroma_auto", {20'h0, chroma_core}, {20'h0, auto_v});
        final_report();
    end
endmodule // decoder_status_clamp_regs_test
